// File: vpg_core.sv
// Purpose: Configuration, indirect access and self-test for a video test-pattern generator
// Assumes: Classic Wishbone slave, 32-bit data, byte address = 4 x register index
// Notes:   Video pins are asynchronous and pass two flip-flops before use
//
// Contract
// RULE_01: Six-bit select set: 64 levels, only six upper colour bits driven.
// RULE_02: Six-bit select clear: full 24-bit colour, 256 levels.
// RULE_03: Internal timing with clock source 1 uses the external pixel clock.
// RULE_04: Internal timing with clock source 0 uses the internal divided clock.
// RULE_05: Clock source bit is ignored while external timing is used.
// RULE_06: Timing select 1: timing built from programmed totals, active, sync, porch.
// RULE_07: Timing select 0: timing taken from incoming clock, enable and syncs.
// RULE_08: Invert bit set inverts colour output; clear passes it unchanged.
// RULE_09: Auto-scroll advances to next pattern after programmed frame count.
// RULE_10: Without auto-scroll the current pattern holds indefinitely.
// RULE_11: An 8-bit indirect address selects the indirect register accessed.
// RULE_12: Host loads the indirect address before each indirect data access.
// RULE_13: Writing indirect data stores into the addressed indirect register.
// RULE_14: Reading indirect data returns the addressed indirect register.
// RULE_15: Self-test enable compares received video against the local pattern.
// RULE_16: Upstream transmitter must send the same pattern during self-test.
// RULE_17: Error flag reads set while self-test error count is non-zero.
// RULE_18: Patterns come out only while the generator enable bit is set.
// RULE_19: Fixed pattern select is ignored while auto-scroll is on.
// RULE_20: Reserved bits read zero and ignore writes.
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
module vpg_core (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        pix_clk_in,
    input  wire logic        pix_de_in,
    input  wire logic        pix_hs_in,
    input  wire logic        pix_vs_in,
    input  wire logic [23:0] pix_rgb_in,
    output logic      [23:0] rgb_out,
    output logic             de_out,
    output logic             hs_out,
    output logic             vs_out
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0]  ctl_reg, cfg_reg, ia_reg, dbg_reg;
    logic [7:0]  ind_mem [vpg_pkg::IND_DEPTH];
    logic [7:0]  errcnt_reg;
    logic        ack_reg;
    logic [31:0] rdat_reg;
    logic [7:0]  rd_next;
    logic        bus_req, bus_wr;
    logic [7:0]  bus_idx;
    logic        gen_en, six_bit, clk_src, tsel, inv, ascrl, bist;
    logic [3:0]  fixed_sel;

    assign bus_req   = wb_cyc_i && wb_stb_i && !ack_reg;
    assign bus_wr    = bus_req && wb_we_i && wb_sel_i[0];
    assign bus_idx   = wb_adr_i[9:2];
    assign gen_en    = ctl_reg[vpg_pkg::CTL_EN];
    assign fixed_sel = ctl_reg[vpg_pkg::CTL_SEL_LSB +: 4];
    assign six_bit   = cfg_reg[vpg_pkg::CFG_SIX_BIT];
    assign clk_src   = cfg_reg[vpg_pkg::CFG_CLK_SRC];
    assign tsel      = cfg_reg[vpg_pkg::CFG_TSEL];
    assign inv       = cfg_reg[vpg_pkg::CFG_INV];
    assign ascrl     = cfg_reg[vpg_pkg::CFG_ASCRL];
    assign bist      = dbg_reg[vpg_pkg::DBG_BIST];

    // Indirect lookup, used only by the bus read path; the timing logic reads ind_mem directly
    function automatic logic [7:0] ind_val(input logic [7:0] idx);
        if (idx == vpg_pkg::IND_ERRCNT) begin
            ind_val = errcnt_reg;
        end else if (idx < 8'(vpg_pkg::IND_DEPTH)) begin
            ind_val = ind_mem[idx[3:0]];
        end else begin
            ind_val = 8'h00;
        end
    endfunction

    // Read mux; registers are read as stored, so reserved bits read zero, and unmapped indices read zero
    always_comb begin
        case (bus_idx)
            vpg_pkg::IDX_CONTROL:  rd_next = ctl_reg;
            vpg_pkg::IDX_CONFIG:   rd_next = cfg_reg;                    // [RULE_20]
            vpg_pkg::IDX_IND_ADDR: rd_next = ia_reg;
            vpg_pkg::IDX_IND_DATA: rd_next = ind_val(ia_reg);            // [RULE_14]
            vpg_pkg::IDX_DEBUG:    rd_next = dbg_reg;
            vpg_pkg::IDX_STATUS:   rd_next = {(bist && errcnt_reg != 8'h00), 7'h00}; // [RULE_17]
            default:               rd_next = 8'h00;
        endcase
    end

    // Bus answer: one-cycle ack the edge after the request is seen
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ack_reg  <= bus_req;
            rdat_reg <= bus_req ? {24'h00_0000, rd_next} : 32'h0000_0000;
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    // Direct registers; write masks keep reserved bits at zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_reg <= vpg_pkg::CTL_RESET;
            cfg_reg <= vpg_pkg::CFG_RESET;
            ia_reg  <= vpg_pkg::IA_RESET;
            dbg_reg <= vpg_pkg::DBG_RESET;
        end else if (bus_wr) begin
            case (bus_idx)
                vpg_pkg::IDX_CONTROL:  ctl_reg <= wb_dat_i[7:0] & vpg_pkg::CTL_WMASK;
                vpg_pkg::IDX_CONFIG:   cfg_reg <= wb_dat_i[7:0] & vpg_pkg::CFG_WMASK; // [RULE_20]
                vpg_pkg::IDX_IND_ADDR: ia_reg  <= wb_dat_i[7:0];                      // [RULE_11]
                vpg_pkg::IDX_DEBUG:    dbg_reg <= wb_dat_i[7:0] & vpg_pkg::DBG_WMASK; // [RULE_20]
                default:               ;
            endcase
        end
    end

    // Indirect array; the error count entry is read-only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < vpg_pkg::IND_DEPTH; i++) begin
                ind_mem[i] <= vpg_pkg::ind_reset(8'(i));
            end
        end else if (bus_wr && bus_idx == vpg_pkg::IDX_IND_DATA && ia_reg < 8'(vpg_pkg::IND_DEPTH)
                     && ia_reg != vpg_pkg::IND_ERRCNT) begin
            ind_mem[ia_reg[3:0]] <= wb_dat_i[7:0];                      // [RULE_13]
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [27:0] pin_s1, pin_s2;
    logic        pclk_d;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 28'h000_0000;
            pin_s2 <= 28'h000_0000;
            pclk_d <= 1'b0;
        end else begin
            pin_s1 <= {pix_clk_in, pix_de_in, pix_hs_in, pix_vs_in, pix_rgb_in};
            pin_s2 <= pin_s1;
            pclk_d <= pin_s2[27];
        end
    end
    logic        ext_de, ext_vs, pclk_edge;
    logic [23:0] ext_rgb;
    assign ext_de    = pin_s2[26];
    assign ext_vs    = pin_s2[24];
    assign ext_rgb   = pin_s2[23:0];
    assign pclk_edge = pin_s2[27] && !pclk_d;

    // ----------------------------------------------------------------
    // Pixel tick
    // ----------------------------------------------------------------
    // Internal divider runs always, so switching sources needs no restart
    logic [1:0] div_reg;
    logic       tick;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= (div_reg == vpg_pkg::DIV_LAST) ? 2'h0 : div_reg + 2'h1;
        end
    end
    // External timing always follows the incoming pixel clock
    assign tick = (!tsel || clk_src) ? pclk_edge                        // [RULE_03] [RULE_05]
                                     : (div_reg == vpg_pkg::DIV_LAST);  // [RULE_04]

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    logic [7:0] hcnt_reg, vcnt_reg;
    logic       ext_de_d, ext_vs_d, frame_end;
    logic       h_wrap, v_wrap;
    logic [8:0] hs_start, vs_start;
    logic       gen_de, gen_hs, gen_vs;
    assign h_wrap    = hcnt_reg == ind_mem[vpg_pkg::IND_H_TOTAL[3:0]];
    assign v_wrap    = vcnt_reg == ind_mem[vpg_pkg::IND_V_TOTAL[3:0]];
    assign frame_end = tick && (tsel ? (h_wrap && v_wrap) : (ext_vs && !ext_vs_d));
    // Sync pulse ends where the back porch begins
    assign hs_start  = 9'(ind_mem[vpg_pkg::IND_H_TOTAL[3:0]]) + 9'h001
                     - 9'(ind_mem[vpg_pkg::IND_H_BACK[3:0]]) - 9'(ind_mem[vpg_pkg::IND_H_SYNC[3:0]]);
    assign vs_start  = 9'(ind_mem[vpg_pkg::IND_V_TOTAL[3:0]]) + 9'h001
                     - 9'(ind_mem[vpg_pkg::IND_V_BACK[3:0]]) - 9'(ind_mem[vpg_pkg::IND_V_SYNC[3:0]]);

    // Internal mode builds its own raster; external mode tracks position in the incoming one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hcnt_reg <= 8'h00;
            vcnt_reg <= 8'h00;
            ext_de_d <= 1'b0;
            ext_vs_d <= 1'b0;
        end else if (tick) begin
            ext_de_d <= ext_de;
            ext_vs_d <= ext_vs;
            if (tsel) begin                                             // [RULE_06]
                hcnt_reg <= h_wrap ? 8'h00 : hcnt_reg + 8'h01;
                if (h_wrap) begin
                    vcnt_reg <= v_wrap ? 8'h00 : vcnt_reg + 8'h01;
                end
            end else begin                                              // [RULE_07]
                hcnt_reg <= ext_de ? hcnt_reg + 8'h01 : 8'h00;
                if (ext_vs) begin
                    vcnt_reg <= 8'h00;
                end else if (ext_de_d && !ext_de) begin
                    vcnt_reg <= vcnt_reg + 8'h01;
                end
            end
        end
    end

    always_comb begin
        if (tsel) begin
            gen_de = hcnt_reg < ind_mem[vpg_pkg::IND_H_ACT[3:0]] && vcnt_reg < ind_mem[vpg_pkg::IND_V_ACT[3:0]];
            gen_hs = (9'(hcnt_reg) >= hs_start)
                  && (9'(hcnt_reg) < hs_start + 9'(ind_mem[vpg_pkg::IND_H_SYNC[3:0]]));
            gen_vs = (9'(vcnt_reg) >= vs_start)
                  && (9'(vcnt_reg) < vs_start + 9'(ind_mem[vpg_pkg::IND_V_SYNC[3:0]]));
            gen_hs = gen_hs ^ ind_mem[vpg_pkg::IND_SYNC[3:0]][vpg_pkg::SYNC_HS_POL];
            gen_vs = gen_vs ^ ind_mem[vpg_pkg::IND_SYNC[3:0]][vpg_pkg::SYNC_VS_POL];
        end else begin
            gen_de = ext_de;
            gen_hs = pin_s2[25];
            gen_vs = ext_vs;
        end
    end

    // ----------------------------------------------------------------
    // Pattern selection and auto-scroll
    // ----------------------------------------------------------------
    logic [3:0] scroll_pat_reg, active_pat;
    logic [7:0] frame_cnt_reg;
    assign active_pat = ascrl ? scroll_pat_reg : fixed_sel;             // [RULE_19]

    // A frame count of zero is treated as one so scrolling never stalls
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scroll_pat_reg <= vpg_pkg::PAT_WHITE;
            frame_cnt_reg  <= 8'h00;
        end else if (!ascrl || !gen_en) begin                           // [RULE_10]
            scroll_pat_reg <= vpg_pkg::PAT_WHITE;
            frame_cnt_reg  <= 8'h00;
        end else if (frame_end) begin
            if (frame_cnt_reg + 8'h01 >= ind_mem[vpg_pkg::IND_FRAMES[3:0]]) begin
                frame_cnt_reg  <= 8'h00;
                scroll_pat_reg <= (scroll_pat_reg >= vpg_pkg::PAT_V_B) ? vpg_pkg::PAT_WHITE
                                                                       : scroll_pat_reg + 4'h1; // [RULE_09]
            end else begin
                frame_cnt_reg <= frame_cnt_reg + 8'h01;
            end
        end
    end

    // Colour for one pixel; reserved and custom codes give black, or white when inversion is set
    function automatic logic [23:0] pat_colour(input logic [3:0] pat, input logic [7:0] hl,
                                               input logic [7:0] vl, input logic six, input logic invc);
        logic [7:0] lvl, msk;
        logic [23:0] c;
        lvl = (pat >= vpg_pkg::PAT_V_W) ? vl : hl;
        msk = six ? vpg_pkg::SIX_MASK : vpg_pkg::FULL_MASK;             // [RULE_01] [RULE_02]
        case (pat)
            vpg_pkg::PAT_WHITE:                   c = 24'hFFFFFF;
            vpg_pkg::PAT_RED:                     c = 24'hFF0000;
            vpg_pkg::PAT_GREEN:                   c = 24'h00FF00;
            vpg_pkg::PAT_BLUE:                    c = 24'h0000FF;
            vpg_pkg::PAT_H_W, vpg_pkg::PAT_V_W:   c = {lvl, lvl, lvl};
            vpg_pkg::PAT_H_R, vpg_pkg::PAT_V_R:   c = {lvl, 16'h0000};
            vpg_pkg::PAT_H_G, vpg_pkg::PAT_V_G:   c = {8'h00, lvl, 8'h00};
            vpg_pkg::PAT_H_B, vpg_pkg::PAT_V_B:   c = {16'h0000, lvl};
            default:                              c = 24'h000000;
        endcase
        if (invc) begin
            c = ~c;                                                     // [RULE_08]
        end
        pat_colour = c & {msk, msk, msk};                               // [RULE_01]
    endfunction

    logic [23:0] gen_rgb;
    assign gen_rgb = pat_colour(active_pat, hcnt_reg, vcnt_reg, six_bit, inv);

    // ----------------------------------------------------------------
    // Video outputs
    // ----------------------------------------------------------------
    // Outputs hold between ticks and are blanked when the generator is off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rgb_out <= 24'h000000;
            de_out  <= 1'b0;
            hs_out  <= 1'b0;
            vs_out  <= 1'b0;
        end else if (!gen_en) begin                                     // [RULE_18]
            rgb_out <= 24'h000000;
            de_out  <= 1'b0;
            hs_out  <= 1'b0;
            vs_out  <= 1'b0;
        end else if (tick) begin
            rgb_out <= gen_de ? gen_rgb : 24'h000000;
            de_out  <= gen_de;
            hs_out  <= gen_hs;
            vs_out  <= gen_vs;
        end
    end

    // ----------------------------------------------------------------
    // Self-test
    // ----------------------------------------------------------------
    // Counter saturates so a long run of errors cannot wrap back to zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            errcnt_reg <= 8'h00;
        end else if (!bist) begin
            errcnt_reg <= 8'h00;
        end else if (gen_en && tick && gen_de && ext_rgb != gen_rgb && errcnt_reg != 8'hFF) begin
            errcnt_reg <= errcnt_reg + 8'h01;                           // [RULE_15]
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    six_bit_mask_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_01]
        six_bit && gen_en && tick |=> rgb_out[1:0] == 2'h0 && rgb_out[9:8] == 2'h0)
        else $error("six-bit mode drove low colour bits");
    int_div_a: assert property (@(posedge clk) disable iff (!rst_n)      // [RULE_04]
        tsel && !clk_src && tick ##1 (tsel && !clk_src) |-> !tick)
        else $error("internal pixel tick faster than divider");
    ext_clk_a: assert property (@(posedge clk) disable iff (!rst_n)      // [RULE_03]
        (tsel && clk_src) |-> tick == ($past(pix_clk_in, 2) && !$past(pix_clk_in, 3)))
        else $error("external pixel clock not followed");
    ext_timing_a: assert property (@(posedge clk) disable iff (!rst_n)   // [RULE_07]
        !tsel && gen_en && tick |=> de_out == $past(ext_de))
        else $error("external data enable not followed");
    int_de_a: assert property (@(posedge clk) disable iff (!rst_n)       // [RULE_06]
        tsel && gen_en && tick && hcnt_reg >= ind_mem[vpg_pkg::IND_H_ACT[3:0]] |=> !de_out)
        else $error("active video outside programmed width");
    hold_pat_a: assert property (@(posedge clk) disable iff (!rst_n)     // [RULE_10]
        !ascrl && !$past(ascrl) && $stable(fixed_sel) |-> $stable(active_pat))
        else $error("pattern changed without auto-scroll");
    ind_write_a: assert property (@(posedge clk) disable iff (!rst_n)    // [RULE_13]
        bus_wr && bus_idx == vpg_pkg::IDX_IND_DATA && ia_reg < vpg_pkg::IND_ERRCNT
        |=> ind_mem[$past(ia_reg[3:0])] == $past(wb_dat_i[7:0]))
        else $error("indirect write lost");
    err_flag_a: assert property (@(posedge clk) disable iff (!rst_n)     // [RULE_17]
        bus_req && !wb_we_i && bus_idx == vpg_pkg::IDX_STATUS
        |=> wb_ack_o && wb_dat_o[vpg_pkg::STS_ERR] == ($past(bist) && $past(errcnt_reg) != 8'h00))
        else $error("self-test error flag wrong");
    off_blank_a: assert property (@(posedge clk) disable iff (!rst_n)    // [RULE_18]
        !gen_en |=> rgb_out == 24'h000000 && !de_out)
        else $error("video driven while disabled");
    cfg_rsvd_a: assert property (@(posedge clk) disable iff (!rst_n)     // [RULE_20]
        cfg_reg[7:5] == 3'h0 && dbg_reg[7:4] == 4'h0 && dbg_reg[2:0] == 3'h0)
        else $error("reserved bits set");
endmodule

// File: vpg_pkg.sv
// Purpose: Shared constants for the video pattern generator configuration block
// Assumes: Registers sit on a 32-bit classic Wishbone bus, one word per register index
// Notes:   Byte address of a register is four times its index
package vpg_pkg;
    // ----------------------------------------------------------------
    // Register indices
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_CONTROL  = 8'h64;
    localparam logic [7:0] IDX_CONFIG   = 8'h65;
    localparam logic [7:0] IDX_IND_ADDR = 8'h66;
    localparam logic [7:0] IDX_IND_DATA = 8'h67;
    localparam logic [7:0] IDX_DEBUG    = 8'h68;
    localparam logic [7:0] IDX_STATUS   = 8'h69;
    // ----------------------------------------------------------------
    // Field positions, write masks and reset values
    // ----------------------------------------------------------------
    localparam int CTL_EN      = 0;
    localparam int CTL_SEL_LSB = 4;
    localparam int CFG_SIX_BIT = 4;
    localparam int CFG_CLK_SRC = 3;
    localparam int CFG_TSEL    = 2;
    localparam int CFG_INV     = 1;
    localparam int CFG_ASCRL   = 0;
    localparam int DBG_BIST    = 3;
    localparam int STS_ERR     = 7;
    localparam int SYNC_HS_POL = 0;
    localparam int SYNC_VS_POL = 1;
    localparam logic [7:0] CTL_WMASK = 8'hF1;
    localparam logic [7:0] CFG_WMASK = 8'h1F;
    localparam logic [7:0] DBG_WMASK = 8'h08;
    localparam logic [7:0] CTL_RESET = 8'h10;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] DBG_RESET = 8'h00;
    localparam logic [7:0] IA_RESET  = 8'h00;
    // ----------------------------------------------------------------
    // Indirect map
    // ----------------------------------------------------------------
    localparam int         IND_DEPTH   = 16;
    localparam logic [7:0] IND_FRAMES  = 8'h00;
    localparam logic [7:0] IND_H_TOTAL = 8'h01;
    localparam logic [7:0] IND_V_TOTAL = 8'h02;
    localparam logic [7:0] IND_H_ACT   = 8'h03;
    localparam logic [7:0] IND_V_ACT   = 8'h04;
    localparam logic [7:0] IND_H_SYNC  = 8'h05;
    localparam logic [7:0] IND_V_SYNC  = 8'h06;
    localparam logic [7:0] IND_H_BACK  = 8'h07;
    localparam logic [7:0] IND_V_BACK  = 8'h08;
    localparam logic [7:0] IND_SYNC    = 8'h09;
    localparam logic [7:0] IND_ERRCNT  = 8'h0A;
    // Default timing: small frame so a simulation sees whole frames quickly
    function automatic logic [7:0] ind_reset(input logic [7:0] idx);
        case (idx)
            IND_FRAMES:  ind_reset = 8'h02;
            IND_H_TOTAL: ind_reset = 8'h1F;
            IND_V_TOTAL: ind_reset = 8'h0F;
            IND_H_ACT:   ind_reset = 8'h18;
            IND_V_ACT:   ind_reset = 8'h0A;
            IND_H_SYNC:  ind_reset = 8'h02;
            IND_V_SYNC:  ind_reset = 8'h01;
            IND_H_BACK:  ind_reset = 8'h02;
            IND_V_BACK:  ind_reset = 8'h01;
            default:     ind_reset = 8'h00;
        endcase
    endfunction
    // ----------------------------------------------------------------
    // Patterns and pixel clock
    // ----------------------------------------------------------------
    localparam logic [3:0] PAT_WHITE = 4'h1;
    localparam logic [3:0] PAT_BLACK = 4'h2;
    localparam logic [3:0] PAT_RED   = 4'h3;
    localparam logic [3:0] PAT_GREEN = 4'h4;
    localparam logic [3:0] PAT_BLUE  = 4'h5;
    localparam logic [3:0] PAT_H_W   = 4'h6;
    localparam logic [3:0] PAT_H_R   = 4'h7;
    localparam logic [3:0] PAT_H_G   = 4'h8;
    localparam logic [3:0] PAT_H_B   = 4'h9;
    localparam logic [3:0] PAT_V_W   = 4'hA;
    localparam logic [3:0] PAT_V_R   = 4'hB;
    localparam logic [3:0] PAT_V_G   = 4'hC;
    localparam logic [3:0] PAT_V_B   = 4'hD;
    localparam logic [7:0] SIX_MASK  = 8'hFC;
    localparam logic [7:0] FULL_MASK = 8'hFF;
    localparam logic [1:0] DIV_LAST  = 2'h1;
endpackage

// File: vpg_upstream_model.sv
// Purpose: Upstream sender: free pixel clock, timing and one colour
// Assumes: Pixel clock runs well below clk/4
// Notes:   Blanked pixels toggle colour so stale data is never mistaken
`timescale 1ns/1ps
module vpg_upstream_model (
    input  wire logic [23:0] colour,
    output logic             pclk,
    output logic             de,
    output logic             hs,
    output logic             vs,
    output logic [23:0]      rgb
);
    logic [3:0] h;
    logic [3:0] v;
    initial {pclk, de, hs, vs, rgb, h, v} = '0;
    // Pixel clock runs free, 160 ns period
    always #80 pclk = ~pclk;
    // Raster of 16x16, ten active pixels a line
    always @(posedge pclk) begin
        h   <= h + 4'h1;
        v   <= (h == 4'hF) ? v + 4'h1 : v;
        de  <= (h < 4'hA);
        hs  <= (h == 4'hC);
        vs  <= (v == 4'h0);
        rgb <= (h < 4'hA) ? colour : ~rgb;
    end
endmodule

// File: test_vpg_core.sv
// Purpose: Self-checking bench for the pattern generator configuration block
// Assumes: Ack one cycle after the taking edge
// Notes:   Pattern red keeps inversion and six-bit masking visible
`timescale 1ns/1ps
module test_vpg_core;
    logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0, ack, de, hs, vs, pclk, pde, phs, pvs;
    logic [9:0]  adr = 10'h000;
    logic [31:0] wdat = 32'h0, rdat;
    logic [23:0] rgb, prgb, colour = 24'hFF0000;
    logic [7:0]  q;
    int          mismatches = 0, n_checks = 0;
    logic [7:0]  cfgs [7] = '{8'h04, 8'h14, 8'h06, 8'h16, 8'h0C, 8'h00, 8'h08};
    logic [23:0] exps [7] = '{24'hFF0000, 24'hFC0000, 24'h00FFFF, 24'h00FCFC, 24'hFF0000, 24'hFF0000, 24'hFF0000};
    always #10 clk = ~clk;
    vpg_core i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pix_clk_in(pclk), .pix_de_in(pde),
        .pix_hs_in(phs), .pix_vs_in(pvs), .pix_rgb_in(prgb), .rgb_out(rgb), .de_out(de), .hs_out(hs), .vs_out(vs));
    vpg_upstream_model i_up (.colour(colour), .pclk(pclk), .de(pde), .hs(phs), .vs(pvs), .rgb(prgb));
    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic cycle: hold until ack is sampled, then release for a cycle
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        cyc  <= 1'b1;
        we   <= w;
        adr  <= {idx, 2'b00};
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        wb(1'b0, idx, 8'h00);
        chk({24'h0, q}, {24'h0, e});
    endtask
    // Let changes settle, then look at one active pixel
    task automatic vid(input logic [23:0] e);
        repeat (200) @(posedge clk);
        while (de !== 1'b1) begin
            @(posedge clk);
        end
        chk({8'h0, rgb}, {8'h0, e});
    endtask
    task automatic finish_test;
        $display("mismatches %0d n_checks %0d", mismatches, n_checks);
        if (mismatches == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // Sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(8'h64, 8'h10);
        rd(8'h65, 8'h00);
        rd(8'h66, 8'h00);
        rd(8'h67, 8'h02);
        rd(8'h68, 8'h00);
        wb(1'b1, 8'h65, 8'hFF);
        rd(8'h65, 8'h1F);
        wb(1'b1, 8'h68, 8'hF7);
        rd(8'h68, 8'h00);
        wb(1'b1, 8'h66, 8'h09);
        wb(1'b1, 8'h67, 8'h03);
        rd(8'h67, 8'h03);
        // An index above the map must not alias onto a low entry
        wb(1'b1, 8'h66, 8'h1B);
        wb(1'b1, 8'h67, 8'h55);
        rd(8'h67, 8'h00);
        rd(8'h70, 8'h00);
        wb(1'b1, 8'h64, 8'h31);
        for (int i = 0; i < 7; i++) begin
            wb(1'b1, 8'h65, cfgs[i]);
            vid(exps[i]);
            // Both sync pulses are inverted, so internal syncs idle high in active video
            if (i < 5) begin
                chk({30'h0, hs, vs}, 32'h3);
            end else begin
                chk({31'h0, hs}, 32'h0);
            end
        end
        // Scroll starts at white; black follows two frames of 1024 cycles later
        wb(1'b1, 8'h65, 8'h05);
        vid(24'hFFFFFF);
        repeat (1700) @(posedge clk);
        vid(24'h000000);
        wb(1'b1, 8'h65, 8'h08);
        // Upstream sends red, the same as the local pattern: no errors
        wb(1'b1, 8'h68, 8'h08);
        repeat (2000) @(posedge clk);
        rd(8'h69, 8'h00);
        colour <= 24'h000000;
        repeat (2000) @(posedge clk);
        rd(8'h69, 8'h80);
        wb(1'b1, 8'h68, 8'h00);
        rd(8'h69, 8'h00);
        wb(1'b1, 8'h64, 8'h30);
        repeat (200) @(posedge clk);
        chk({5'h0, de, hs, vs, rgb}, 32'h0);
        finish_test();
    end
    // Watchdog: all tests fit well inside this span
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        finish_test();
    end
endmodule
